// ==== rtl/sfr_fault.sv ====
// fault latching, clearing, autoretry and diagnostic flags, four outputs
`timescale 1ns/1ps
`include "sfr_regs.svh"
// Summary of operation
// RL1 - battery low: all outputs off, fault pin low, supply-low flag set
// RL2 - battery back, commands off: pin high, flag held until status read
// RL3 - battery back, command on: pin stays low, output stays latched off
// RL4 - latched fault clears after condition ends plus retry, toggle or reset
// RL5 - logic-supply fail or power-on reset clears every latched fault; code skips the logic-fail clear while battery is low
// RL6 - retry request is overcurrent or overtemp of output or supply-low
// RL7 - retry after one retry period, at most 16 retries per output
// RL8 - retry counters cleared on any normal/fail-safe mode change
// RL9 - each retry restores default inrush overcurrent profile
// RL10 - short to supply while off latches short and off-openload flags
// RL11 - status read clears short flag once short has gone
// RL12 - short detection disableable per output
// RL13 - off openload latches flag, read clears it once gone and pin high
// RL14 - off openload detection disableable per output
// RL15 - on openload sets flag, no effect on output or fault pin
// RL16 - LED mode: on openload checked each period only at full duty
// RL17 - on openload flag clears after condition gone and read; disableable
// RL18 - in normal mode temperature prewarning latches, cleared by read
// RL19 - supply above clamp: cancel turn-off, switch all outputs on
// RL20 - logic-supply fail with enable set returns settings to defaults
// RL21 - without logic supply direct inputs drive outputs, zero settings
// RL22 - battery loss with logic good keeps settings, reports supply-low
// RL23 - fault pin low for present faults or latched pin faults
// RL24 - latched flags returned then cleared by first valid status read
module sfr_fault #(
  parameter int N         = `SFR_NUM_OUT,
  parameter int RETRY_MAX = `SFR_RETRY_MAX,
  parameter int RETRY_CYC = `SFR_RETRY_CYC,
  parameter int LED_CYC   = `SFR_LED_CYC
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         batt_low_pin,
  input  wire logic         clamp_pin,
  input  wire logic [N-1:0] overcurrent_pin,
  input  wire logic [N-1:0] overtemp_pin,
  input  wire logic [N-1:0] short_pin,
  input  wire logic [N-1:0] openload_off_pin,
  input  wire logic [N-1:0] openload_on_pin,
  input  wire logic         prewarn_pin,
  input  wire logic         logic_fail_pin,
  input  wire logic [N-1:0] direct_in,
  input  wire logic [N-1:0] spi_cmd_on,
  input  wire logic [6:0]   duty_code,
  input  wire logic         normal_mode,
  input  wire logic         status_read,
  input  wire logic         fail_clear_en,
  input  wire logic         retry_disable,
  input  wire logic [N-1:0] short_detect_disable,
  input  wire logic [N-1:0] off_openload_disable,
  input  wire logic [N-1:0] on_openload_disable,
  input  wire logic [N-1:0] led_threshold_select,
  output logic      [N-1:0] switch_output,
  output logic              fault_report_pin_b,
  output logic              supply_low_flag,
  output logic      [N-1:0] overcurrent_flag,
  output logic      [N-1:0] overtemp_flag,
  output logic      [N-1:0] short_to_supply_flag,
  output logic      [N-1:0] off_state_openload_flag,
  output logic      [N-1:0] on_state_openload_flag,
  output logic              temp_prewarning_flag,
  output logic      [N-1:0] inrush_restart,
  output logic              settings_clear
);
  localparam int SW = 4 * N + 4;
  localparam int RW = $clog2(RETRY_MAX + 1);
  if (N < 1 || RETRY_MAX < 1)
  begin : g_bad_par
    $error("sfr_fault: bad parameters");
  end
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  sfr_sync #(.W(SW)) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .din     ({batt_low_pin, clamp_pin, prewarn_pin, logic_fail_pin,
                overcurrent_pin, overtemp_pin, short_pin, openload_off_pin}),
    .dout    (syn)
  );
  assign raw = syn;
  logic         c_uv;
  logic         c_clamp;
  logic         c_prew;
  logic         c_lfail;
  logic [N-1:0] c_oc;
  logic [N-1:0] c_ot;
  logic [N-1:0] c_os;
  logic [N-1:0] c_oloff;
  assign {c_uv, c_clamp, c_prew, c_lfail, c_oc, c_ot, c_os, c_oloff} = raw;
  logic [N-1:0] c_olon;
  sfr_sync #(.W(N)) u_sync_on (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .din     (openload_on_pin),
    .dout    (c_olon)
  );
  // ****************************************************************
  // timers
  // ****************************************************************
  logic retry_tick;
  logic led_tick;
  sfr_timer #(.CYC(RETRY_CYC)) u_rtmr (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .restart (1'b0),
    .tick    (retry_tick)
  );
  sfr_timer #(.CYC(LED_CYC)) u_ltmr (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .restart (1'b0),
    .tick    (led_tick)
  );
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed
  {
    logic [N-1:0]         latch_off;
    logic [N-1:0]         cmd_prev;
    logic [N-1:0][RW-1:0] rcnt;
    sfr_pkg::sfr_rt_e [N-1:0] rst_st;
    logic [N-1:0]         inrush;
    logic                 mode_prev;
    logic                 lfail_prev;
    logic                 uv;
    logic [N-1:0]         oc;
    logic [N-1:0]         ot;
    logic [N-1:0]         os;
    logic [N-1:0]         oloff;
    logic [N-1:0]         olon;
    logic                 prew;
    logic                 clr_set;
    logic [N-1:0]         sw;
    logic                 fs_b;
  } sfr_st_s;
  sfr_st_s st_ff;
  sfr_st_s nxt_st;
  // effective settings are zero while logic supply is gone
  logic [N-1:0] eff_osdis;
  logic [N-1:0] eff_oloffdis;
  logic [N-1:0] eff_olondis;
  logic [N-1:0] eff_led;
  logic [N-1:0] cmd;
  logic         eff_rdis;
  always_comb
  begin
    eff_osdis    = c_lfail ? '0 : short_detect_disable;   // RL12 RL21
    eff_oloffdis = c_lfail ? '0 : off_openload_disable;   // RL14 RL21
    eff_olondis  = c_lfail ? '0 : on_openload_disable;    // RL17
    eff_led      = c_lfail ? '0 : led_threshold_select;
    eff_rdis     = c_lfail ? 1'b0 : retry_disable;
    cmd          = c_lfail ? direct_in : (direct_in | spi_cmd_on);  // RL21
  end
  logic [N-1:0] det_os;
  logic [N-1:0] det_oloff;
  logic [N-1:0] det_olon;
  logic         lfail_rise;
  logic         mode_chg;
  always_comb
  begin
    nxt_st     = st_ff;
    det_os     = c_os & ~cmd & ~eff_osdis;                 // RL10 RL12
    det_oloff  = (c_oloff | det_os) & ~cmd & ~eff_oloffdis; // RL10 RL13
    for (int i = 0; i < N; i++)
    begin
      // LED threshold only sampled on the periodic check at full duty
      if (eff_led[i])
        det_olon[i] = led_tick && duty_code == `SFR_DUTY_FULL &&
                      st_ff.sw[i] && c_olon[i];              // RL16
      else
        det_olon[i] = st_ff.sw[i] & c_olon[i];               // RL15
    end
    det_olon   = det_olon & ~eff_olondis;                   // RL17
    lfail_rise = c_lfail & ~st_ff.lfail_prev;
    mode_chg   = normal_mode != st_ff.mode_prev;
    nxt_st.mode_prev  = normal_mode;
    nxt_st.lfail_prev = c_lfail;
    nxt_st.cmd_prev   = cmd;
    nxt_st.clr_set    = lfail_rise & fail_clear_en;         // RL20
    nxt_st.inrush     = '0;
    // read clears only gone conditions; a new event the same cycle wins
    if (status_read)                                        // RL24
    begin
      nxt_st.uv    = c_uv;                                  // RL2 RL22
      nxt_st.oc    = c_oc;
      nxt_st.ot    = c_ot;
      nxt_st.os    = c_os & st_ff.os;                       // RL11
      nxt_st.oloff = st_ff.fs_b ? '0 : st_ff.oloff;         // RL13
      nxt_st.olon  = c_olon & st_ff.olon;                   // RL17
      nxt_st.prew  = 1'b0;                                  // RL18
    end
    nxt_st.uv    = nxt_st.uv | c_uv;                        // RL1
    nxt_st.oc    = nxt_st.oc | (c_oc & st_ff.sw);
    nxt_st.ot    = nxt_st.ot | c_ot;
    nxt_st.os    = nxt_st.os | det_os;                      // RL10
    nxt_st.oloff = nxt_st.oloff | det_oloff;                // RL10 RL13
    nxt_st.olon  = nxt_st.olon | det_olon;                  // RL15
    nxt_st.prew  = nxt_st.prew | (normal_mode & c_prew);    // RL18
    for (int i = 0; i < N; i++)
    begin
      // output latch: oc, ot while on, and undervoltage while on
      if (cmd[i] && (c_oc[i] || c_ot[i] || c_uv))           // RL1 RL3
        nxt_st.latch_off[i] = 1'b1;
      else if (!st_ff.cmd_prev[i] && cmd[i] && !c_oc[i] && !c_ot[i])
      begin
        nxt_st.latch_off[i] = 1'b0;                         // RL4
        nxt_st.inrush[i]    = 1'b1;
      end
      unique case (st_ff.rst_st[i])
        sfr_pkg::SFR_RT_IDLE:
        begin
          if (st_ff.latch_off[i] && !eff_rdis &&
              (st_ff.oc[i] || st_ff.ot[i] || st_ff.uv))     // RL6
            nxt_st.rst_st[i] = sfr_pkg::SFR_RT_WAIT;
        end
        sfr_pkg::SFR_RT_WAIT:
        begin
          if (!st_ff.latch_off[i])
            nxt_st.rst_st[i] = sfr_pkg::SFR_RT_IDLE;
          else if (retry_tick && !c_oc[i] && !c_ot[i] && !c_uv)
          begin
            nxt_st.latch_off[i] = 1'b0;                     // RL4 RL7
            nxt_st.inrush[i]    = 1'b1;                     // RL9
            nxt_st.rcnt[i]      = st_ff.rcnt[i] + RW'(1);
            nxt_st.rst_st[i]    = (st_ff.rcnt[i] == RW'(RETRY_MAX - 1)) ?
                                  sfr_pkg::SFR_RT_DONE : sfr_pkg::SFR_RT_IDLE;
          end
        end
        sfr_pkg::SFR_RT_DONE:
          nxt_st.rst_st[i] = sfr_pkg::SFR_RT_DONE;          // RL7
        default:
          nxt_st.rst_st[i] = sfr_pkg::SFR_RT_IDLE;
      endcase
    end
    if (mode_chg)                                           // RL8
    begin
      nxt_st.rcnt      = '0;
      for (int i = 0; i < N; i++)
        nxt_st.rst_st[i] = sfr_pkg::SFR_RT_IDLE;
      nxt_st.latch_off = '0;
    end
    if (lfail_rise && !c_uv)                                // RL5
    begin
      nxt_st.latch_off = '0;
      nxt_st.uv        = 1'b0;
      nxt_st.oc        = '0;
      nxt_st.ot        = '0;
    end
    // clamp overrides every turn-off path
    if (c_clamp)                                            // RL19
      nxt_st.sw = '1;
    else if (c_uv)
      nxt_st.sw = '0;                                       // RL1
    else
      nxt_st.sw = cmd & ~nxt_st.latch_off & ~c_oc & ~c_ot;
    nxt_st.fs_b = !(c_uv || (|nxt_st.latch_off) || (|c_ot) ||
                    (|det_os) || (|det_oloff));             // RL23 RL2 RL3
  end
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff      <= '0;
      st_ff.fs_b <= 1'b1;
      // matches the normal mode level, so reset is not taken as a mode change
      st_ff.mode_prev <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end
  assign switch_output           = st_ff.sw;
  assign fault_report_pin_b      = st_ff.fs_b;
  assign supply_low_flag         = st_ff.uv;
  assign overcurrent_flag        = st_ff.oc;
  assign overtemp_flag           = st_ff.ot;
  assign short_to_supply_flag    = st_ff.os;
  assign off_state_openload_flag = st_ff.oloff;
  assign on_state_openload_flag  = st_ff.olon;
  assign temp_prewarning_flag    = st_ff.prew;
  assign inrush_restart          = st_ff.inrush;
  assign settings_clear          = st_ff.clr_set;
  // ****************************************************************
  // checks
  // ****************************************************************
  uv_outputs_off_a : assert property (@(posedge sys_clk) disable iff (!rst_b) // RL1
    (c_uv && !c_clamp) |=> (switch_output == '0 && !fault_report_pin_b && supply_low_flag))
    else $error("undervoltage did not force outputs off");
  clamp_all_on_a : assert property (@(posedge sys_clk) disable iff (!rst_b) // RL19
    c_clamp |=> switch_output == '1)
    else $error("clamp did not switch outputs on");
  uv_flag_hold_a : assert property (@(posedge sys_clk) disable iff (!rst_b) // RL2
    (supply_low_flag && !status_read && !lfail_rise) |=> supply_low_flag)
    else $error("supply low flag dropped without read");
  prew_hold_a : assert property (@(posedge sys_clk) disable iff (!rst_b) // RL18
    (temp_prewarning_flag && !status_read) |=> temp_prewarning_flag)
    else $error("prewarning dropped without read");
  mode_clear_a : assert property (@(posedge sys_clk) disable iff (!rst_b) // RL8
    mode_chg |=> (st_ff.rcnt == '0))
    else $error("retry counters not cleared on mode change");
  olon_no_pin_a : assert property (@(posedge sys_clk) disable iff (!rst_b) // RL15
    (det_olon[0] && cmd[0] && fault_report_pin_b && !c_uv && !(|c_oc) && !(|c_ot) &&
     !(|det_os) && !(|det_oloff)) |=> (switch_output[0] && fault_report_pin_b))
    else $error("on openload disturbed output or fault pin");
  short_latch_a : assert property (@(posedge sys_clk) disable iff (!rst_b) // RL10
    det_os[0] |=> (short_to_supply_flag[0] && off_state_openload_flag[0] ||
                   eff_oloffdis[0]) && !fault_report_pin_b)
    else $error("short to supply not latched");
  settings_clear_a : assert property (@(posedge sys_clk) disable iff (!rst_b) // RL20
    (lfail_rise && fail_clear_en) |=> settings_clear)
    else $error("settings not cleared on logic supply fail");
  retry_limit_a : assert property (@(posedge sys_clk) disable iff (!rst_b) // RL7
    st_ff.rst_st[0] == sfr_pkg::SFR_RT_DONE |-> st_ff.rcnt[0] == RW'(RETRY_MAX))
    else $error("retry count exceeded");
endmodule : sfr_fault

// ==== rtl/sfr_pkg.sv ====
// types shared by the switch fault and retry logic
package sfr_pkg;
  typedef enum logic [1:0]
  {
    SFR_RT_IDLE = 2'b00,
    SFR_RT_WAIT = 2'b01,
    SFR_RT_DONE = 2'b10
  } sfr_rt_e;
endpackage : sfr_pkg

// ==== rtl/sfr_regs.svh ====
// timing and layout constants for the switch fault and retry logic
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH
`define SFR_NUM_OUT        4
`define SFR_RETRY_MAX      16
`define SFR_RETRY_PERIOD_US 150
`define SFR_LED_PERIOD_US  2000
`define SFR_CLK_MHZ        20
`define SFR_RETRY_CYC      (`SFR_RETRY_PERIOD_US * `SFR_CLK_MHZ)
`define SFR_LED_CYC        (`SFR_LED_PERIOD_US * `SFR_CLK_MHZ)
`define SFR_DUTY_FULL      7'h7F
`endif

// ==== rtl/sfr_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sfr_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sfr_sync_s;
  sfr_sync_s st_ff;
  sfr_sync_s nxt_st;
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < W; i++)
    begin
      // change counts only once stages two and three agree
      if (st_ff.s2[i] == st_ff.s3[i])
        nxt_st.q[i] = st_ff.s3[i];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign dout = st_ff.q;
endmodule : sfr_sync

// ==== rtl/sfr_timer.sv ====
// free-running period tick divider
`timescale 1ns/1ps
module sfr_timer #(
  parameter int CYC = 3000
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic restart,
  output logic      tick
);
  localparam int CW = $clog2(CYC + 1);
  // a period under two cycles would leave no idle count between ticks
  if (CYC < 2)
  begin : g_bad_cyc
    $error("sfr_timer: CYC too small");
  end
  typedef struct packed
  {
    logic [CW-1:0] cnt;
    logic          tk;
  } sfr_tmr_s;
  sfr_tmr_s st_ff;
  sfr_tmr_s nxt_st;
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.tk = 1'b0;
    if (restart)
      nxt_st.cnt = '0;
    else if (st_ff.cnt == CW'(CYC - 1))
    begin
      nxt_st.cnt = '0;
      nxt_st.tk  = 1'b1;
    end
    else
      nxt_st.cnt = st_ff.cnt + CW'(1);
  end
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign tick = st_ff.tk;
endmodule : sfr_timer

// ==== tb/sfr_mcu_model.sv ====
// microcontroller model: output commands and status reads
`timescale 1ns/1ps
module sfr_mcu_model (
  input  wire logic       sys_clk,
  input  wire logic       supply_low_flag,
  output logic      [3:0] spi_cmd_on,
  output logic      [3:0] direct_in,
  output logic            status_read,
  output logic            seen_low
);
  initial
  begin
    spi_cmd_on  = 4'h0;
    direct_in   = 4'h0;
    status_read = 1'b0;
    seen_low    = 1'b0;
  end
  // snapshot taken before the clearing edge, as a real reader shifts it out
  task automatic read_status();
    @(negedge sys_clk);
    status_read = 1'b1;
    seen_low    = supply_low_flag;
    @(negedge sys_clk);
    status_read = 1'b0;
  endtask : read_status
  // command held for as long as the caller waits afterwards
  task automatic command(input logic [3:0] spi, input logic [3:0] dir);
    @(negedge sys_clk);
    spi_cmd_on = spi;
    direct_in  = dir;
  endtask : command
endmodule : sfr_mcu_model

// ==== tb/switch_fault_retry_diagnostics_tb_top.sv ====
// self-checking bench for the fault, retry and diagnostic logic
`timescale 1ns/1ps
`define SFR_CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module switch_fault_retry_diagnostics_tb_top;
  logic sys_clk = 1'b0, rst_b = 1'b0;
  logic batt_low_pin = 1'b0, clamp_pin = 1'b0, prewarn_pin = 1'b0, logic_fail_pin = 1'b0;
  logic [3:0] oc_pin = 4'h0, ot_pin = 4'h0, sh_pin = 4'h0, olf_pin = 4'h0, oln_pin = 4'h0;
  logic [3:0] sh_dis = 4'h0, olf_dis = 4'h0, oln_dis = 4'h0, led_sel = 4'h0;
  logic [6:0] duty_code = 7'h00;
  logic normal_mode = 1'b1, fail_clear_en = 1'b0, retry_disable = 1'b0, short_load = 1'b0;
  logic [3:0] spi_cmd_on, direct_in, switch_output, ocf, otf, shf, olff, olnf, inrush;
  logic status_read, seen_low, fs_b, uvf, otwf, sclr;
  logic [31:0] lfsr = 32'h187fbb48;
  int err_total = 0, total_checks = 0, pulse_cnt = 0, sc_cnt = 0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (inrush[0]) pulse_cnt++;
    if (sclr) sc_cnt++;
  end
  // shorted load: overcurrent shows only while output 0 conducts
  always @(negedge sys_clk) oc_pin <= {3'h0, short_load & switch_output[0]};
  sfr_mcu_model i_mcu (.sys_clk(sys_clk), .supply_low_flag(uvf), .spi_cmd_on(spi_cmd_on),
    .direct_in(direct_in), .status_read(status_read), .seen_low(seen_low));
  sfr_fault #(.RETRY_CYC(4), .LED_CYC(8)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .batt_low_pin(batt_low_pin), .clamp_pin(clamp_pin), .overcurrent_pin(oc_pin),
    .overtemp_pin(ot_pin), .short_pin(sh_pin), .openload_off_pin(olf_pin),
    .openload_on_pin(oln_pin), .prewarn_pin(prewarn_pin), .logic_fail_pin(logic_fail_pin),
    .direct_in(direct_in), .spi_cmd_on(spi_cmd_on), .duty_code(duty_code),
    .normal_mode(normal_mode), .status_read(status_read), .fail_clear_en(fail_clear_en),
    .retry_disable(retry_disable), .short_detect_disable(sh_dis),
    .off_openload_disable(olf_dis), .on_openload_disable(oln_dis),
    .led_threshold_select(led_sel), .switch_output(switch_output),
    .fault_report_pin_b(fs_b), .supply_low_flag(uvf), .overcurrent_flag(ocf),
    .overtemp_flag(otf), .short_to_supply_flag(shf), .off_state_openload_flag(olff),
    .on_state_openload_flag(olnf), .temp_prewarning_flag(otwf), .inrush_restart(inrush),
    .settings_clear(sclr));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // outputs are the OR of both command sources while no fault holds them
  function automatic logic [3:0] exp_out(input logic [3:0] spi, input logic [3:0] dir);
    exp_out = spi | dir;
  endfunction : exp_out
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic tend(input string name);
    $display("test %s done, checks %0d, errors %0d", name, total_checks, err_total);
  endtask : tend
  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  initial
  begin
    #400000;
    err_total++;
    final_report();
  end
  initial
  begin
    logic [3:0] s, d;
    cyc(3);
    rst_b = 1'b1;
    `SFR_CHK(switch_output, 4'h0)
    `SFR_CHK(fs_b, 1'b1)
    cyc(4);
    batt_low_pin = 1'b1;
    cyc(8);
    `SFR_CHK(uvf, 1'b1)
    `SFR_CHK(fs_b, 1'b0)
    batt_low_pin = 1'b0;
    cyc(8);
    `SFR_CHK(fs_b, 1'b1)
    `SFR_CHK(uvf, 1'b1)
    i_mcu.read_status();
    cyc(1);
    `SFR_CHK(seen_low, 1'b1)
    `SFR_CHK(uvf, 1'b0)
    tend("supply_low");
    repeat (4)
    begin
      lfsr = lfsr_next(lfsr);
      s = lfsr[3:0];
      d = lfsr[7:4];
      i_mcu.command(s, d);
      cyc(4);
      `SFR_CHK(switch_output, exp_out(s, d))
    end
    i_mcu.command(4'h1, 4'h0);
    cyc(2);
    short_load = 1'b1;
    cyc(8);
    `SFR_CHK(ocf[0], 1'b1)
    `SFR_CHK(fs_b, 1'b0)
    pulse_cnt = 0;
    cyc(600);
    `SFR_CHK(pulse_cnt, 16)
    `SFR_CHK(switch_output[0], 1'b0)
    normal_mode = 1'b0;
    cyc(10);
    normal_mode = 1'b1;
    cyc(20);
    `SFR_CHK(pulse_cnt > 16, 1'b1)
    short_load = 1'b0;
    cyc(40);
    `SFR_CHK(switch_output[0], 1'b1)
    i_mcu.read_status();
    cyc(1);
    `SFR_CHK(ocf[0], 1'b0)
    tend("retry");
    i_mcu.command(4'h0, 4'h0);
    clamp_pin = 1'b1;
    cyc(8);
    `SFR_CHK(switch_output, 4'hF)
    clamp_pin = 1'b0;
    cyc(8);
    i_mcu.read_status();
    sh_dis = 4'h2;
    sh_pin = 4'h3;
    cyc(8);
    `SFR_CHK(shf, 4'h1)
    `SFR_CHK(olff[0], 1'b1)
    `SFR_CHK(fs_b, 1'b0)
    sh_pin = 4'h0;
    cyc(8);
    `SFR_CHK(fs_b, 1'b1)
    i_mcu.read_status();
    cyc(1);
    `SFR_CHK(shf, 4'h0)
    `SFR_CHK(olff, 4'h0)
    olf_dis = 4'hE;
    olf_pin = 4'hF;
    cyc(8);
    `SFR_CHK(olff, 4'h1)
    olf_pin = 4'h0;
    cyc(8);
    i_mcu.read_status();
    tend("short_openload");
    i_mcu.command(4'hF, 4'h0);
    duty_code = 7'h7F;
    oln_dis = 4'h8;
    oln_pin = 4'hF;
    cyc(10);
    `SFR_CHK(olnf, 4'h7)
    `SFR_CHK(switch_output, 4'hF)
    `SFR_CHK(fs_b, 1'b1)
    oln_pin = 4'h0;
    cyc(8);
    i_mcu.read_status();
    cyc(1);
    `SFR_CHK(olnf, 4'h0)
    led_sel = 4'h1;
    duty_code = 7'h10;
    oln_pin = 4'h1;
    cyc(30);
    `SFR_CHK(olnf[0], 1'b0)
    duty_code = 7'h7F;
    cyc(30);
    `SFR_CHK(olnf[0], 1'b1)
    tend("on_openload");
    retry_disable = 1'b1;
    ot_pin = 4'h2;
    cyc(8);
    `SFR_CHK(otf, 4'h2)
    `SFR_CHK(switch_output[1], 1'b0)
    `SFR_CHK(fs_b, 1'b0)
    ot_pin = 4'h0;
    cyc(12);
    `SFR_CHK(switch_output[1], 1'b0)
    retry_disable = 1'b0;
    cyc(12);
    `SFR_CHK(switch_output[1], 1'b1)
    i_mcu.read_status();
    cyc(1);
    `SFR_CHK(otf, 4'h0)
    tend("overtemp");
    prewarn_pin = 1'b1;
    cyc(8);
    prewarn_pin = 1'b0;
    cyc(8);
    `SFR_CHK(otwf, 1'b1)
    i_mcu.read_status();
    cyc(1);
    `SFR_CHK(otwf, 1'b0)
    fail_clear_en = 1'b1;
    sc_cnt = 0;
    logic_fail_pin = 1'b1;
    cyc(10);
    `SFR_CHK(sc_cnt, 1)
    `SFR_CHK(switch_output, 4'h0)
    logic_fail_pin = 1'b0;
    cyc(8);
    tend("prewarn_logic_fail");
    final_report();
  end
endmodule : switch_fault_retry_diagnostics_tb_top
